// >>> stcf_pkg.sv
// Purpose: constants and carrier types for the spi transfer control block
// Assumes: 25 MHz sys_clk, register port with one-cycle read latency
// Notes: register offsets are byte addresses of 32-bit words
// Operation
// R1: reorder set sends and receives each word least significant byte first
// R2: pause set with 32-bit width inserts suspend plus two clocks after each byte; code skips it for a byte that ends a transaction (trans_end)
// R3: inter-byte pause does nothing unless word width selects 32-bit words
// R4: role bit 0 selects master, 1 selects slave
// R5: done interrupt reaches cpu only while its enable bit is one
// R6: done flag low during transfer, set at its end, interrupt if enabled
// R7: writing one clears the done flag, writing zero leaves it
// R8: master only suspend gap between transactions, falling to rising edge at polarity 0
// R9: suspend interval field resets to zero
// R10: zero transaction count makes suspend field act only through byte gap
// R11: polarity one measures gap from rising to falling edge
package stcf_pkg;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] CLR_OFS = 4'h8;
  localparam logic [3:0] IEN_OFS = 4'hC;
  localparam int REORDER_BIT = 20;
  localparam int PAUSE_BIT = 19;
  localparam int SLAVE_BIT = 18;
  localparam int IEN_BIT = 17;
  localparam int FLAG_BIT = 16;
  localparam int SUSP_LSB = 12;
  localparam int POL_BIT = 11;
  localparam int WID_LSB = 8;
  localparam int CNT_LSB = 0;
  localparam logic [3:0] SUSP_RST = 4'h0;
  localparam logic [1:0] WIDTH_32 = 2'h0;
  localparam logic [4:0] GAP_EXTRA = 5'h02;
  typedef struct packed {
    logic reorder;
    logic pause_en;
    logic slave;
    logic [3:0] suspend_gap_len;
    logic serial_clock_polarity;
    logic [1:0] word_width_sel;
    logic [1:0] transaction_count;
  } stcf_ctrl_t;
  localparam stcf_ctrl_t CTRL_RST = '{1'b0, 1'b0, 1'b0, SUSP_RST, 1'b0, 2'h0, 2'h0};
endpackage

// >>> stcf_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to sys_clk
// Notes: first stage read only by second
`timescale 1ns/10ps
module stcf_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end
  assign q = s2_reg;
endmodule // stcf_sync

// >>> stcf_gap.sv
// Purpose: counts link clock cycles of an idle gap
// Assumes: edge pulses from synchronised link clock
// Notes: done pulses once after len counted cycles
`timescale 1ns/10ps
module stcf_gap (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [4:0] len,
  input wire logic cyc_edge,
  output logic busy,
  output logic done
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;
  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start) begin
      cnt_next = len;
      busy_next = (len != 5'h00);
      done_next = (len == 5'h00);
    end else if (busy_reg && cyc_edge) begin
      cnt_next = cnt_reg - 5'h01;
      if (cnt_reg == 5'h01) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_reg <= 5'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end
  assign busy = busy_reg;
  assign done = done_reg;
endmodule // stcf_gap

// >>> stcf_top.sv
// Purpose: transfer control fields of an spi port: order, gaps, role, done flag
// Assumes: shifter reports byte and transaction ends as sys_clk pulses
// Notes: link clock pin is sampled and its edges found on sys_clk
`timescale 1ns/10ps
module stcf_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic sclk_pin,
  input wire logic xfer_start,
  input wire logic byte_end,
  input wire logic trans_end,
  input wire logic xfer_end,
  input wire logic [1:0] byte_idx,
  output logic [1:0] lane_sel,
  output logic slave_mode,
  output logic shift_hold,
  output logic irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  stcf_pkg::stcf_ctrl_t ctrl_reg;
  stcf_pkg::stcf_ctrl_t ctrl_next;
  logic xfer_done_flag_reg;
  logic xfer_done_flag_next;
  logic xfer_done_irq_en_reg;
  logic xfer_done_irq_en_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic [1:0] lane_reg;
  logic [1:0] lane_next;
  logic slave_reg;
  logic hold_reg;
  logic hold_next;
  logic sclk_s;
  logic sclk_d_reg;
  logic rise;
  logic fall;
  logic gap_edge;
  logic byte_gap_go;
  logic trans_gap_go;
  logic gap_busy;
  logic gap_done;
  logic [4:0] gap_len;

  stcf_sync #(.W(1)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .d(sclk_pin),
    .q(sclk_s)
  );

  // ------------------------------------------------------------
  // link clock edges
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
    end
  end
  assign rise = sclk_s & ~sclk_d_reg;
  assign fall = ~sclk_s & sclk_d_reg;
  // gap counts whole cycles on the idle-to-active edge
  assign gap_edge = ctrl_reg.serial_clock_polarity ? fall : rise; // R8 R11

  // ------------------------------------------------------------
  // gap control
  // ------------------------------------------------------------
  assign byte_gap_go = byte_end && ctrl_reg.pause_en && !trans_end
    && (ctrl_reg.word_width_sel == stcf_pkg::WIDTH_32); // R2 R3
  assign trans_gap_go = trans_end && !xfer_end && !ctrl_reg.slave
    && (ctrl_reg.transaction_count != 2'h0); // R8 R10
  always_comb begin
    gap_len = {1'b0, ctrl_reg.suspend_gap_len};
    if (byte_gap_go) begin
      gap_len = {1'b0, ctrl_reg.suspend_gap_len} + stcf_pkg::GAP_EXTRA; // R2
    end
  end

  stcf_gap u_gap (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(byte_gap_go | trans_gap_go),
    .len(gap_len),
    .cyc_edge(gap_edge),
    .busy(gap_busy),
    .done(gap_done)
  );

  // ------------------------------------------------------------
  // datapath control
  // ------------------------------------------------------------
  always_comb begin
    hold_next = gap_busy | byte_gap_go | trans_gap_go;
    if (gap_done) begin
      hold_next = 1'b0;
    end
    lane_next = ctrl_reg.reorder ? byte_idx : ~byte_idx; // R1
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    xfer_done_irq_en_next = xfer_done_irq_en_reg;
    xfer_done_flag_next = xfer_done_flag_reg;
    rdata_next = 32'h00000000;
    if (wr && addr == stcf_pkg::CTRL_OFS) begin
      ctrl_next.reorder = wdata[stcf_pkg::REORDER_BIT];
      ctrl_next.pause_en = wdata[stcf_pkg::PAUSE_BIT];
      ctrl_next.slave = wdata[stcf_pkg::SLAVE_BIT]; // R4
      ctrl_next.suspend_gap_len = wdata[stcf_pkg::SUSP_LSB +: 4];
      ctrl_next.serial_clock_polarity = wdata[stcf_pkg::POL_BIT];
      ctrl_next.word_width_sel = wdata[stcf_pkg::WID_LSB +: 2];
      ctrl_next.transaction_count = wdata[stcf_pkg::CNT_LSB +: 2];
      xfer_done_irq_en_next = wdata[stcf_pkg::IEN_BIT];
    end
    if (wr && addr == stcf_pkg::IEN_OFS) begin
      xfer_done_irq_en_next = wdata[stcf_pkg::FLAG_BIT];
    end
    if (wr && (addr == stcf_pkg::CTRL_OFS || addr == stcf_pkg::CLR_OFS)
        && wdata[stcf_pkg::FLAG_BIT]) begin
      xfer_done_flag_next = 1'b0; // R7
    end
    if (xfer_start) begin
      xfer_done_flag_next = 1'b0; // R6
    end
    if (xfer_end) begin
      xfer_done_flag_next = 1'b1; // R6
    end
    if (rd) begin
      unique case (addr)
        stcf_pkg::CTRL_OFS: begin
          rdata_next[stcf_pkg::REORDER_BIT] = ctrl_reg.reorder;
          rdata_next[stcf_pkg::PAUSE_BIT] = ctrl_reg.pause_en;
          rdata_next[stcf_pkg::SLAVE_BIT] = ctrl_reg.slave;
          rdata_next[stcf_pkg::IEN_BIT] = xfer_done_irq_en_reg;
          rdata_next[stcf_pkg::FLAG_BIT] = xfer_done_flag_reg;
          rdata_next[stcf_pkg::SUSP_LSB +: 4] = ctrl_reg.suspend_gap_len;
          rdata_next[stcf_pkg::POL_BIT] = ctrl_reg.serial_clock_polarity;
          rdata_next[stcf_pkg::WID_LSB +: 2] = ctrl_reg.word_width_sel;
          rdata_next[stcf_pkg::CNT_LSB +: 2] = ctrl_reg.transaction_count;
        end
        stcf_pkg::STAT_OFS: begin
          rdata_next[stcf_pkg::FLAG_BIT] = xfer_done_flag_reg;
        end
        stcf_pkg::IEN_OFS: begin
          rdata_next[stcf_pkg::FLAG_BIT] = xfer_done_irq_en_reg;
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
    irq_next = xfer_done_flag_next & xfer_done_irq_en_next; // R5 R6
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg <= stcf_pkg::CTRL_RST; // R9
      xfer_done_flag_reg <= 1'b0;
      xfer_done_irq_en_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      irq_reg <= 1'b0;
      lane_reg <= 2'h3;
      slave_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      xfer_done_flag_reg <= xfer_done_flag_next;
      xfer_done_irq_en_reg <= xfer_done_irq_en_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      lane_reg <= lane_next;
      slave_reg <= ctrl_reg.slave; // R4
      hold_reg <= hold_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign lane_sel = lane_reg;
  assign slave_mode = slave_reg;
  assign shift_hold = hold_reg;
endmodule // stcf_top

// >>> stcf_asserts.sv
// Purpose: port-level checks of the transfer control block
// Assumes: bound to stcf_top
// Notes: flag and enable are seen only through irq
`timescale 1ns/10ps
module stcf_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic xfer_start,
  input wire logic byte_end,
  input wire logic trans_end,
  input wire logic xfer_end,
  input wire logic [1:0] byte_idx,
  input wire logic [1:0] lane_sel,
  input wire logic slave_mode,
  input wire logic shift_hold,
  input wire logic irq
);
  logic reorder_seen_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // mirrors the reorder bit as software writes it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reorder_seen_reg <= 1'b0;
    end else if (wr && addr == stcf_pkg::CTRL_OFS) begin
      reorder_seen_reg <= wdata[stcf_pkg::REORDER_BIT];
    end
  end
  chk_lane_map: assert property (
    !$past(sys_rst) |-> lane_sel == ($past(reorder_seen_reg) ? $past(byte_idx)
      : 2'h3 - $past(byte_idx))) else $error("lane");
  chk_role_write: assert property (
    $changed(slave_mode) |-> $past(wr) || $past(wr, 2)) else $error("role");
  chk_irq_cause: assert property (
    $rose(irq) |-> $past(xfer_end) || $past(wr) || $past(wr, 2)) else $error("irq rise");
  chk_irq_sticky: assert property (
    irq && !xfer_start && !wr && !$past(wr) |=> irq) else $error("irq drop");
  chk_start_clr: assert property (xfer_start && !xfer_end |=> !irq) else $error("start");
  chk_w1c_clr: assert property (
    wr && addr == stcf_pkg::CLR_OFS && wdata[stcf_pkg::FLAG_BIT] && !xfer_end |=> !irq)
    else $error("w1c");
  chk_hold_cause: assert property (
    $rose(shift_hold) |-> $past(byte_end || trans_end)) else $error("hold cause");
  chk_hold_bound: assert property (
    $rose(shift_hold) |-> ##[1:160] !shift_hold) else $error("hold len");
  cover property ($rose(irq));
  cover property ($rose(shift_hold));
  cover property ($rose(slave_mode));
endmodule // stcf_asserts
bind stcf_top stcf_asserts u_chk (.*);

// >>> stcf_link_model.sv
// Purpose: far-side serial clock source
// Assumes: run is raised only while a gap is timed
// Notes: rests at the polarity level outside frames
`timescale 1ns/10ps
module stcf_link_model (
  input wire logic run,
  input wire logic pol,
  output logic sclk_pin
);
  // 320 ns period, offset so edges never meet sys_clk edges
  initial begin
    sclk_pin = 1'b0;
    #7;
    forever begin
      #160;
      sclk_pin = run ? ~sclk_pin : pol;
    end
  end
endmodule // stcf_link_model

// >>> tb_spi_transfer_control_fields.sv
// Purpose: self-checking bench for stcf_top
// Assumes: read data stand one cycle after the strobe
// Notes: gap lengths allow slack for pin sync
`timescale 1ns/10ps
module tb_spi_transfer_control_fields;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [1:0] byte_idx = 2'h0;
  logic run = 1'b0;
  logic pol = 1'b0;
  logic [31:0] rdata;
  logic [1:0] lane_sel;
  logic sclk_pin, slave_mode, shift_hold, irq;
  int mismatches = 0;
  int samples_checked = 0;
  always #20 sys_clk = ~sys_clk;
  stcf_link_model u_link (.run, .pol, .sclk_pin);
  stcf_top DUT (.sys_clk, .sys_rst, .addr, .wdata, .wr, .rd, .rdata, .sclk_pin,
    .xfer_start(ev[3]), .byte_end(ev[2]), .trans_end(ev[1]), .xfer_end(ev[0]),
    .byte_idx, .lane_sel, .slave_mode, .shift_hold, .irq);
  // ------
  // tasks
  // ------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // w=1 writes d, w=0 reads and compares with d
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 if (!w) chk(rdata, d);
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge sys_clk);
    ev <= v;
    @(posedge sys_clk);
    ev <= 4'h0;
    #1;
  endtask
  task automatic gap(input logic [31:0] ctrl, input logic [3:0] v, input int len);
    int n;
    n = 0;
    pol = ctrl[stcf_pkg::POL_BIT];
    bus(1, stcf_pkg::CTRL_OFS, ctrl);
    run = 1'b1;
    pulse(v);
    while (shift_hold && n < 400) begin
      @(posedge sys_clk) #1 n++;
    end
    run = 1'b0;
    chk(32'(n >= len * 8 - 8 && n <= (len ? len * 8 + 12 : 0)), 32'h1);
  endtask
  task automatic end_sim();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ------
  // tests
  // ------
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus(0, stcf_pkg::CTRL_OFS, 32'h0);
    bus(0, 4'h2, 32'h0);
    chk(32'(lane_sel), 32'h3);
    for (int r = 0; r < 2; r++) begin
      bus(1, stcf_pkg::CTRL_OFS, 32'(r) << stcf_pkg::REORDER_BIT);
      for (int i = 0; i < 4; i++) begin
        @(posedge sys_clk);
        byte_idx <= 2'(i);
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(lane_sel), r ? 32'(i) : 32'(3 - i));
      end
    end
    bus(1, stcf_pkg::CTRL_OFS, 32'h0004_0000);
    @(posedge sys_clk) #1 chk(32'(slave_mode), 32'h1);
    pulse(4'h1);
    chk(32'(irq), 32'h0);
    bus(0, stcf_pkg::STAT_OFS, 32'h0001_0000);
    bus(1, stcf_pkg::IEN_OFS, 32'h0001_0000);
    @(posedge sys_clk) #1 chk(32'(irq), 32'h1);
    bus(1, stcf_pkg::CLR_OFS, 32'h0);
    @(posedge sys_clk) #1 chk(32'(irq), 32'h1);
    bus(1, stcf_pkg::CLR_OFS, 32'h0001_0000);
    @(posedge sys_clk) #1 chk(32'(irq), 32'h0);
    bus(0, stcf_pkg::STAT_OFS, 32'h0);
    pulse(4'h1);
    pulse(4'h8);
    bus(0, stcf_pkg::STAT_OFS, 32'h0);
    gap(32'h0008_1000, 4'h4, 3);
    gap(32'h0008_1100, 4'h4, 0);
    gap(32'h0000_3001, 4'h2, 3);
    gap(32'h0004_3001, 4'h2, 0);
    gap(32'h0000_3000, 4'h2, 0);
    gap(32'h0000_3801, 4'h2, 3);
    end_sim();
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule // tb_spi_transfer_control_fields
